// ===== shared/ts_marker_consts.vh
// Constants for the timestamp marker and user pattern register block.
// Assumes the includer compares word indices taken from AXI byte address bits [11:2].
`ifndef TS_MARKER_CONSTS_VH
`define TS_MARKER_CONSTS_VH

// Register indices; byte address is four times the index.
`define IDX_TS_CTRL    10'h160
`define IDX_POS_SEL    10'h161
`define IDX_PAT0       10'h180
`define IDX_PAT1       10'h182
`define IDX_PAT2       10'h184
`define IDX_PAT3       10'h186
`define IDX_OUT_CTRL   10'h1A0
`define IDX_STATUS     10'h1A1

// Reset values.
`define RST_TS_CTRL    8'h00
`define RST_POS_SEL    8'h00
`define RST_PAT0       16'h0000
`define RST_PAT1       16'h0FFF
`define RST_PAT2       16'h0000
`define RST_PAT3       16'h0FFF
`define RST_OUT_CTRL   8'h00

// Field positions.
`define BIT_MARK_EN    0
`define BIT_LANE_SEL   0
`define BIT_IF_EN      0
`define BIT_PAT_SRC    1
`define BIT_RECV_EN    2
`define FLD_WIDTH_HI   5
`define FLD_WIDTH_LO   4

// Output sample width codes.
`define WID_12         2'h0
`define WID_11         2'h1
`define WID_8          2'h2

// Effective LSB lane for each width.
`define LANE_W12       4'h0
`define LANE_W11       4'h1
`define LANE_W8        4'h4

// Bus and pipeline shape.
`define NBUS           4
`define SW             12
`define SDLY           4
`define LANES_ON       12'hFFF
`define RESP_OKAY      2'h0
`define RESP_SLVERR    2'h2
`endif

// ===== hw/timestamp_marker_and_user_pattern.v
// Timestamp marker insertion and user test pattern for four 12-lane sample buses.
// Assumes ADC samples arrive on sys_clk; the timestamp pin and link clock are asynchronous.
//
// Overview of operation
// - With the marker enable and receive enable bits set and samples selected, each output sample carries the timestamp in its LSB.
// - The marker is delayed through the block by exactly the latency the samples see.
// - With lane select at 0 the marker rides on lane 0 of every bus at any sample width.
// - With lane select at 0 lane 0 of each bus stays enabled whatever the sample width.
// - With lane select at 1 the marker sits on the LSB of the effective sample width.
// - That LSB is lane 0 for 12-bit, lane 1 for 11-bit and lane 4 for 8-bit samples.
// - Bits 11 to 0 of the first pattern register give pattern sample 0; bits 15 to 12 are spare.
// - Pattern sample 1 comes from the second pattern register, reset to all twelve bits set.
// - Pattern sample 2 has its own register, reset to zero.
// - The pattern words can be sent on the output buses as a test pattern.
// - Pattern sample 3 sits at the next even index, reset to all twelve bits set.
`include "ts_marker_consts.vh"
`timescale 1ns/1ps

module timestamp_marker_and_user_pattern (
  input  wire        sys_clk,
  input  wire        rst_n,
  input  wire [11:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [11:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire [47:0] adc_sample,
  input  wire        timestamp_pin,
  input  wire        link_clk_pin,
  output reg  [47:0] out_data,
  output reg  [47:0] out_lane_en
);

  // Register storage.
  reg  [7:0]  ts_ctrl_reg;
  reg  [7:0]  pos_sel_reg;
  reg  [7:0]  out_ctrl_reg;
  reg  [15:0] pat_reg [0:3];

  // Write channel holding state.
  reg  [9:0]  aw_idx_reg;
  reg         aw_full_reg;
  reg  [31:0] w_data_reg;
  reg  [3:0]  w_strb_reg;
  reg         w_full_reg;

  // Synchronisers and detected levels.
  reg  [2:0]  ts_sync_reg;
  reg         ts_state_reg;
  reg  [2:0]  lk_sync_reg;
  reg         lk_level_reg;
  reg  [1:0]  pat_idx_reg;

  // Sample delay line matching the marker synchroniser.
  reg  [47:0] dly_reg [0:`SDLY-1];

  wire        if_en   = out_ctrl_reg[`BIT_IF_EN];
  wire        pat_src = out_ctrl_reg[`BIT_PAT_SRC];
  wire        recv_en = out_ctrl_reg[`BIT_RECV_EN];
  wire [1:0]  width   = out_ctrl_reg[`FLD_WIDTH_HI:`FLD_WIDTH_LO];
  wire        lane_sel = pos_sel_reg[`BIT_LANE_SEL];

  wire        lk_new  = (lk_sync_reg[1] == lk_sync_reg[2]) ? lk_sync_reg[2] : lk_level_reg;
  wire        lk_rise = lk_new & ~lk_level_reg;

  integer     i;

  // Maps an address to its 3-bit register code; 7 means unmapped.
  function [2:0] reg_code;
    input [11:0] addr;
    begin
      case (addr[11:2])
        `IDX_TS_CTRL:  reg_code = 3'h0;
        `IDX_POS_SEL:  reg_code = 3'h1;
        `IDX_PAT0:     reg_code = 3'h2;
        `IDX_PAT1:     reg_code = 3'h3;
        `IDX_PAT2:     reg_code = 3'h4;
        `IDX_PAT3:     reg_code = 3'h5;
        `IDX_OUT_CTRL: reg_code = 3'h6;
        `IDX_STATUS:   reg_code = 3'h6;
        default:       reg_code = 3'h7;
      endcase
    end
  endfunction

  // Merges write data into a 16-bit register under the two low byte strobes.
  function [15:0] merge16;
    input [15:0] old;
    input [31:0] data;
    input [3:0]  strb;
    begin
      merge16[7:0]  = strb[0] ? data[7:0] : old[7:0];
      merge16[15:8] = strb[1] ? data[15:8] : old[15:8];
    end
  endfunction

  // Lowest active lane for a sample width code.
  function [3:0] lsb_lane;
    input [1:0] w;
    begin
      case (w)
        `WID_11: lsb_lane = `LANE_W11;
        `WID_8:  lsb_lane = `LANE_W8;
        default: lsb_lane = `LANE_W12;
      endcase
    end
  endfunction

  // Lanes that the configured width and lane select leave switched on.
  wire [3:0]  eff_lane  = lsb_lane(width);
  wire [11:0] lane_mask = (`LANES_ON << eff_lane) | {11'h000, ~lane_sel};
  wire [3:0]  mark_lane = lane_sel ? eff_lane : `LANE_W12;
  wire        mark_on   = ts_ctrl_reg[`BIT_MARK_EN] & recv_en;
  wire [11:0] pat_word  = pat_reg[pat_idx_reg][11:0];

  // Write address and data are held independently, then committed together.
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OKAY;
      aw_full_reg   <= 1'b0;
      w_full_reg    <= 1'b0;
      aw_idx_reg    <= 10'h000;
      w_data_reg    <= 32'h00000000;
      w_strb_reg    <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_idx_reg    <= s_axi_awaddr[11:2];
        aw_full_reg   <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data_reg   <= s_axi_wdata;
        w_strb_reg   <= s_axi_wstrb;
        w_full_reg   <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (aw_full_reg && w_full_reg && !s_axi_bvalid) begin
        aw_full_reg  <= 1'b0;
        w_full_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (reg_code({aw_idx_reg, 2'h0}) == 3'h7) ? `RESP_SLVERR : `RESP_OKAY;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // Register writes; reserved bits are kept and read back as written.
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      ts_ctrl_reg  <= `RST_TS_CTRL;
      pos_sel_reg  <= `RST_POS_SEL;
      out_ctrl_reg <= `RST_OUT_CTRL;
      pat_reg[0]   <= `RST_PAT0;
      pat_reg[1]   <= `RST_PAT1;
      pat_reg[2]   <= `RST_PAT2;
      pat_reg[3]   <= `RST_PAT3;
    end else if (aw_full_reg && w_full_reg && !s_axi_bvalid) begin
      case (reg_code({aw_idx_reg, 2'h0}))
        3'h0: ts_ctrl_reg <= w_strb_reg[0] ? w_data_reg[7:0] : ts_ctrl_reg;
        3'h1: pos_sel_reg <= w_strb_reg[0] ? w_data_reg[7:0] : pos_sel_reg;
        3'h2: pat_reg[0] <= merge16(pat_reg[0], w_data_reg, w_strb_reg);
        3'h3: pat_reg[1] <= merge16(pat_reg[1], w_data_reg, w_strb_reg);
        3'h4: pat_reg[2] <= merge16(pat_reg[2], w_data_reg, w_strb_reg);
        3'h5: pat_reg[3] <= merge16(pat_reg[3], w_data_reg, w_strb_reg);
        3'h6: begin
          if (aw_idx_reg == `IDX_OUT_CTRL) begin
            out_ctrl_reg <= w_strb_reg[0] ? w_data_reg[7:0] : out_ctrl_reg;
          end
        end
        default: ;
      endcase
    end
  end

  // Read channel: one read at a time, answered the cycle after the address.
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= `RESP_OKAY;
      case (reg_code(s_axi_araddr))
        3'h0: s_axi_rdata <= {24'h000000, ts_ctrl_reg};
        3'h1: s_axi_rdata <= {24'h000000, pos_sel_reg};
        3'h2: s_axi_rdata <= {16'h0000, pat_reg[0]};
        3'h3: s_axi_rdata <= {16'h0000, pat_reg[1]};
        3'h4: s_axi_rdata <= {16'h0000, pat_reg[2]};
        3'h5: s_axi_rdata <= {16'h0000, pat_reg[3]};
        3'h6: begin
          if (s_axi_araddr[11:2] == `IDX_OUT_CTRL) begin
            s_axi_rdata <= {24'h000000, out_ctrl_reg};
          end else begin
            s_axi_rdata <= {27'h0000000, lk_level_reg, pat_idx_reg, 1'b0, ts_state_reg};
          end
        end
        default: begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= `RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // Pin synchronisers; a new level counts once stages two and three agree.
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      ts_sync_reg  <= 3'h0;
      lk_sync_reg  <= 3'h0;
      ts_state_reg <= 1'b0;
      lk_level_reg <= 1'b0;
    end else begin
      ts_sync_reg  <= {ts_sync_reg[1:0], timestamp_pin};
      lk_sync_reg  <= {lk_sync_reg[1:0], link_clk_pin};
      lk_level_reg <= lk_new;
      if (ts_sync_reg[1] == ts_sync_reg[2]) begin
        ts_state_reg <= ts_sync_reg[2];
      end
    end
  end

  // Pattern index steps on each link clock rising edge while the pattern is sent, and wraps; otherwise it rests at 0.
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      pat_idx_reg <= 2'h0;
    end else if (!if_en || !pat_src) begin
      pat_idx_reg <= 2'h0;
    end else if (lk_rise) begin
      pat_idx_reg <= pat_idx_reg + 2'h1;
    end
  end

  // Sample delay equal to the marker synchroniser depth.
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      for (i = 0; i < `SDLY; i = i + 1) begin
        dly_reg[i] <= 48'h000000000000;
      end
    end else begin
      dly_reg[0] <= adc_sample;
      for (i = 1; i < `SDLY; i = i + 1) begin
        dly_reg[i] <= dly_reg[i-1];
      end
    end
  end

  // Output buses: pattern or delayed samples, marker inserted, unused lanes off.
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      out_data    <= 48'h000000000000;
      out_lane_en <= 48'h000000000000;
    end else if (!if_en) begin
      out_data    <= 48'h000000000000;
      out_lane_en <= 48'h000000000000;
    end else begin
      for (i = 0; i < `NBUS; i = i + 1) begin
        out_lane_en[i*`SW +: `SW] <= lane_mask;
        if (pat_src) begin
          out_data[i*`SW +: `SW] <= pat_word & lane_mask;
        end else if (mark_on) begin
          out_data[i*`SW +: `SW] <= ((dly_reg[`SDLY-1][i*`SW +: `SW]
            & ~(12'h001 << mark_lane)) | ({11'h000, ts_state_reg} << mark_lane))
            & lane_mask;
        end else begin
          out_data[i*`SW +: `SW] <= dly_reg[`SDLY-1][i*`SW +: `SW] & lane_mask;
        end
      end
    end
  end

endmodule

// ===== bench/ts_marker_sva.sv
// Handshake and lane-map checks for the marker block.
// Assumes a bind into the block; sees its ports only.
`timescale 1ns/1ps
module ts_marker_sva (
  input logic        sys_clk,
  input logic        rst_n,
  input logic        s_axi_awvalid,
  input logic        s_axi_awready,
  input logic        s_axi_wvalid,
  input logic        s_axi_wready,
  input logic        s_axi_bvalid,
  input logic        s_axi_bready,
  input logic        s_axi_arvalid,
  input logic        s_axi_arready,
  input logic        s_axi_rvalid,
  input logic        s_axi_rready,
  input logic [47:0] out_data,
  input logic [47:0] out_lane_en
);
  // All checks use the block clock and rest during reset.
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  // A write answers one cycle after both halves are held; a read one cycle after its address.
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##2 s_axi_bvalid) else $error("no write answer");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("no read answer");
  // A taken response reopens its channel next cycle.
  a_b_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid
    && s_axi_awready && s_axi_wready) else $error("write not reopened");
  a_r_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid
    && s_axi_arready) else $error("read not reopened");
  a_write_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write open too soon");
  // Buses share one lane map and dark lanes stay low.
  a_buses_alike: assert property (out_lane_en == {4{out_lane_en[11:0]}})
    else $error("buses differ");
  a_lane_map: assert property (|out_lane_en |-> out_lane_en[11:0] inside
    {12'hFFF, 12'hFFE, 12'hFF0, 12'hFF1}) else $error("bad lane map");
  a_dark_lanes: assert property ((out_data & ~out_lane_en) == 48'h0)
    else $error("dark lane driven");
endmodule

bind timestamp_marker_and_user_pattern ts_marker_sva chk_u (.*);

// ===== bench/link_partner.sv
// Capture-side model that supplies the link clock.
// Assumes the bench raises run while the link toggles.
`timescale 1ns/1ps
module link_partner (
  input  logic run,
  output logic link_clk_pin
);
  // The clock idles low and has a 125 ns period while running.
  initial begin
    link_clk_pin = 1'b0;
    #3;
    forever begin
      #62.5;
      link_clk_pin = run & ~link_clk_pin;
    end
  end
endmodule

// ===== bench/timestamp_marker_and_user_pattern_tb.sv
// Self-checking bench for the marker and pattern block.
// Assumes link_partner supplies the link clock.
`include "ts_marker_consts.vh"
`timescale 1ns/1ps
module timestamp_marker_and_user_pattern_tb;
  logic        sys_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        awv = 1'b0, wv = 1'b0, arv = 1'b0, tsp = 1'b0, run = 1'b0;
  logic        awr, wrd, bv, arr, rv, lck;
  logic [1:0]  bre, rre;
  logic [3:0]  ws = 4'hF;
  logic [11:0] awa = 12'h0, ara = 12'h0, last;
  logic [31:0] wd = 32'h0, rdat, seed = 32'h8D2417C8;
  logic [47:0] smp = 48'h0, od, oe;
  logic [15:0] pw [4];
  int          bad_count = 0, compares = 0, j, n;

  // Both response channels are always accepted.
  timestamp_marker_and_user_pattern dut_u (.sys_clk(sys_clk), .rst_n(rst_n),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(bre),
    .s_axi_bvalid(bv), .s_axi_bready(1'b1), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rre), .s_axi_rvalid(rv),
    .s_axi_rready(1'b1), .adc_sample(smp), .timestamp_pin(tsp), .link_clk_pin(lck),
    .out_data(od), .out_lane_en(oe));
  link_partner peer_u (.run(run), .link_clk_pin(lck));
  // The 100 MHz block clock.
  always #5 sys_clk = ~sys_clk;

  // Counts one comparison and reports a mismatch.
  task automatic chk(input [47:0] g, input [47:0] e);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Ends the run when a bounded wait ran out.
  task automatic lim(input bit f);
    if (f) begin
      bad_count++;
      $display("unexpected at %0t: wait ran out", $time);
      report_and_stop;
    end
  endtask

  // One register write; each channel drops once taken.
  task automatic wr(input [9:0] i, input [31:0] d, input [1:0] r);
    awa <= {i, 2'b00};
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
      if (awr) awv <= 1'b0;
      if (wrd) wv <= 1'b0;
    end while (!bv && n < 40);
    lim(n >= 40);
    chk(48'(bre), 48'(r));
  endtask

  // One register read compared with its expected word.
  task automatic rd(input [9:0] i, input [31:0] e, input [1:0] r);
    ara <= {i, 2'b00};
    arv <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
      if (arr) arv <= 1'b0;
    end while (!rv && n < 40);
    lim(n >= 40);
    chk(48'(rdat), e);
    chk(48'(rre), 48'(r));
  endtask

  // Random source for samples and pattern words.
  function automatic [31:0] lfsr(input [31:0] x);
    lfsr = {x[30:0], 1'b0} ^ (x[31] ? 32'h04C11DB7 : 32'h0);
  endfunction

  // Lanes that stay on for a width code and lane select.
  function automatic [11:0] lanes(input [1:0] w, input sel);
    lanes = (w == 2'h1) ? 12'hFFE : (w == 2'h2) ? 12'hFF0 : 12'hFFF;
    lanes[0] = lanes[0] | !sel;
  endfunction

  // Drives a sample, a different one next, and checks the first five edges on.
  // The timestamp level is held, since the pin filter drops one-cycle pulses.
  task automatic step(input [1:0] w, input sel, input m);
    logic [47:0] e;
    int          b;
    seed = lfsr(seed);
    e = {seed[15:0], seed} & {4{lanes(w, sel)}};
    for (b = 0; b < 4; b++)
      if (m) e[12 * b + (!sel ? 0 : w == 2'h1 ? 1 : w == 2'h2 ? 4 : 0)] = seed[7];
    @(posedge sys_clk);
    smp <= {seed[15:0], seed};
    tsp <= seed[7];
    @(posedge sys_clk);
    smp <= ~{seed[15:0], seed};
    repeat (4) @(posedge sys_clk);
    #1;
    chk(od, e);
    chk(oe, {4{lanes(w, sel)}});
  endtask

  // Main sequence: registers, sample path, then pattern.
  initial begin
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    #1;
    chk(od | oe, 48'h0);
    rd(`IDX_TS_CTRL, 32'h0, 2'h0);
    rd(`IDX_POS_SEL, 32'h0, 2'h0);
    rd(`IDX_PAT0, 32'h0, 2'h0);
    rd(`IDX_PAT1, 32'hFFF, 2'h0);
    rd(`IDX_PAT2, 32'h0, 2'h0);
    rd(`IDX_PAT3, 32'hFFF, 2'h0);
    rd(10'h000, 32'h0, 2'h2);
    wr(10'h000, 32'h1, 2'h2);
    for (j = 0; j < 4; j++) begin
      seed = lfsr(seed);
      pw[j] = {seed[15:12], 1'b1, 2'(j), seed[8:0]};
      wr(10'(`IDX_PAT0 + 2 * j), 32'(pw[j]), 2'h0);
      rd(10'(`IDX_PAT0 + 2 * j), 32'(pw[j]), 2'h0);
    end
    ws <= 4'h1;
    wr(`IDX_PAT3, 32'h0, 2'h0);
    ws <= 4'hF;
    pw[3][7:0] = 8'h0;
    rd(`IDX_PAT3, 32'(pw[3]), 2'h0);
    wr(`IDX_TS_CTRL, 32'h1, 2'h0);
    for (j = 0; j < 8; j++) begin
      wr(`IDX_POS_SEL, 32'(j % 2), 2'h0);
      wr(`IDX_OUT_CTRL, 32'(j / 2) << 4 | 32'h5, 2'h0);
      repeat (2) step(2'(j / 2), j % 2, 1'b1);
    end
    wr(`IDX_OUT_CTRL, 32'h1, 2'h0);
    step(2'h0, 1'b1, 1'b0);
    wr(`IDX_TS_CTRL, 32'h0, 2'h0);
    wr(`IDX_OUT_CTRL, 32'h5, 2'h0);
    step(2'h0, 1'b1, 1'b0);
    wr(`IDX_OUT_CTRL, 32'h0, 2'h0);
    wr(`IDX_OUT_CTRL, 32'h3, 2'h0);
    run <= 1'b1;
    last = 12'h0;
    j = 0;
    n = 0;
    while (j < 6 && n < 400) begin
      @(posedge sys_clk);
      #1;
      n++;
      if (od[11:0] !== last) begin
        chk(od, {4{pw[j % 4][11:0]}});
        last = od[11:0];
        j++;
      end
    end
    lim(n >= 400);
    report_and_stop;
  end
endmodule
